// ### usp_pkg.sv
// constants for the serial port shadow data window
package usp_pkg;
    // byte addresses of the sixteen mirrored data words
    localparam logic [31:0] USP_SHADOW_BASE = 32'h5000_1130;
    localparam logic [31:0] USP_SHADOW_WORD_11 = 32'h5000_115C;
    localparam logic [31:0] USP_SHADOW_WORD_12 = 32'h5000_1160;
    localparam logic [31:0] USP_SHADOW_SPAN = 32'h0000_0040;
    // control and status words placed after the window
    localparam logic [31:0] USP_CTRL_ADDR = 32'h5000_1170;
    localparam logic [31:0] USP_STAT_ADDR = 32'h5000_1174;
    // control bits: queue enable, infrared mode
    localparam int USP_CTRL_QEN = 0;
    localparam int USP_CTRL_IR = 1;
    localparam logic [1:0] USP_CTRL_RESET = 2'h0;
    // status bits: data ready, overrun (write one to clear), tx holding empty
    localparam int USP_STAT_DR = 0;
    localparam int USP_STAT_OVR = 1;
    localparam int USP_STAT_TX_HOLDING_EMPTY_FLAG = 5;
    localparam int USP_STAT_RXCNT = 8;
    localparam int USP_STAT_TXCNT = 16;
    // bus answers
    localparam logic [1:0] USP_RESP_OKAY = 2'h0;
    localparam logic [1:0] USP_RESP_SLVERR = 2'h2;
    localparam logic [7:0] USP_BYTE_RESET = 8'h00;
endpackage : usp_pkg

// ### usp_shadow_port.sv
// serial port shadow data window: receive and transmit queues behind AXI4-Lite
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
module usp_shadow_port
    import usp_pkg::*;
#(
    parameter int DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic reset,
    // AXI4-Lite slave
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // bytes from the line and infrared deserialisers
    input wire logic [7:0] rxLineByte,
    input wire logic rxLineValid,
    input wire logic [7:0] rxIrByte,
    input wire logic rxIrValid,
    // byte to the serialiser; txOnIr picks the infrared output
    output logic [7:0] txByte,
    output logic txValid,
    output logic txOnIr,
    input wire logic txTaken,
    // flags for the line status logic
    output logic dataReady,
    output logic overrunErr,
    output logic txHoldEmpty
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    // pointer wrap needs a power-of-two depth; the status count fields fit up to 64
    if (DEPTH < 2 || DEPTH > 64 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("usp_shadow_port: DEPTH must be a power of two from 2 to 64");
    end

    logic [7:0] rxMem [DEPTH];  // receive queue storage
    logic [7:0] txMem [DEPTH];  // transmit queue storage
    logic [PW-1:0] rxWr_reg, rxRd_reg, txWr_reg, txRd_reg;
    logic [CW-1:0] rxCnt_reg, txCnt_reg;
    logic [1:0] ctrl_reg;       // queue enable, infrared mode
    logic ovr_reg;              // sticky overrun
    logic [31:0] awAddr_reg;    // captured write address
    logic [31:0] wData_reg;     // captured write data
    logic wStrb0_reg;           // low byte lane enabled
    logic awHave_reg, wHave_reg;
    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic [7:0] txByte_reg;
    logic txValid_reg, txOnIr_reg;

    // mode selects
    wire qEn = ctrl_reg[USP_CTRL_QEN];
    wire irMode = ctrl_reg[USP_CTRL_IR];

    // address decode: any aligned word of the window is the data port
    wire wrShadow = (awAddr_reg >= USP_SHADOW_BASE)
        && (awAddr_reg < USP_SHADOW_BASE + USP_SHADOW_SPAN)
        && (awAddr_reg[1:0] == 2'h0);
    wire wrCtrl = (awAddr_reg == USP_CTRL_ADDR);
    wire wrStat = (awAddr_reg == USP_STAT_ADDR);
    wire rdShadow = (araddr >= USP_SHADOW_BASE)
        && (araddr < USP_SHADOW_BASE + USP_SHADOW_SPAN)
        && (araddr[1:0] == 2'h0);
    wire rdCtrl = (araddr == USP_CTRL_ADDR);
    wire rdStat = (araddr == USP_STAT_ADDR);

    // bus events
    wire wrDo = awHave_reg && wHave_reg && !bvalid_reg;
    wire rdDo = arvalid && arready_reg;
    wire wrOk = wrShadow || wrCtrl || wrStat;
    wire rdOk = rdShadow || rdCtrl || rdStat;

    // toggling queue enable flushes both queues, as a classic port does
    wire qFlush = wrDo && wrCtrl && (wData_reg[USP_CTRL_QEN] != qEn);

    // receive side: infrared input replaces the line input in infrared mode
    wire rxPush = irMode ? rxIrValid : rxLineValid;
    wire [7:0] rxIn = irMode ? rxIrByte : rxLineByte;
    wire rxPop = rdDo && rdShadow && (rxCnt_reg != '0);
    wire rxFull = qEn ? (rxCnt_reg == CW'(DEPTH)) : (rxCnt_reg != '0);
    wire rxBlocked = rxFull && !rxPop;
    wire rxStore = rxPush && !rxBlocked;
    wire rxOverwrite = rxPush && rxBlocked && !qEn;
    wire rxOverrun = rxPush && rxBlocked;
    wire [7:0] rxHead = rxMem[rxRd_reg];

    // transmit side: low lane only, reserved upper three bytes dropped
    wire txWrite = wrDo && wrShadow && wStrb0_reg;
    wire txPop = (txCnt_reg != '0) && (!txValid_reg || txTaken);
    wire txFull = qEn ? (txCnt_reg == CW'(DEPTH)) : (txCnt_reg != '0);
    wire txBlocked = txFull && !txPop;
    wire txStore = txWrite && !txBlocked;
    wire txOverwrite = txWrite && txBlocked && !qEn;

    // read data mux; upper bits of the data word always zero
    wire [31:0] statWord = {{(16-CW){1'b0}}, txCnt_reg, {(8-CW){1'b0}}, rxCnt_reg,
        2'h0, (txCnt_reg == '0), 3'h0, ovr_reg, (rxCnt_reg != '0)};
    wire [31:0] rdMux = rdShadow ? {24'h0, rxHead} :
        rdCtrl ? {30'h0, ctrl_reg} : rdStat ? statWord : 32'h0;

    // receive queue storage
    always_ff @(posedge clk_sys) begin
        if (rxStore) begin
            rxMem[rxWr_reg] <= rxIn;
        end else if (rxOverwrite) begin
            rxMem[rxRd_reg] <= rxIn;
        end
    end

    // receive pointers and fill level
    always_ff @(posedge clk_sys) begin
        if (reset || qFlush) begin
            rxWr_reg <= '0;
            rxRd_reg <= '0;
            rxCnt_reg <= '0;
        end else begin
            if (rxStore) begin
                rxWr_reg <= rxWr_reg + PW'(1);
            end
            if (rxPop) begin
                rxRd_reg <= rxRd_reg + PW'(1);
            end
            // a full queue keeps its level when the arrival is dropped
            rxCnt_reg <= rxCnt_reg + CW'(rxStore) - CW'(rxPop);
        end
    end

    // sticky overrun: a new overrun beats a clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ovr_reg <= 1'b0;
        end else if (rxOverrun) begin
            ovr_reg <= 1'b1;
        end else if (wrDo && wrStat && wData_reg[USP_STAT_OVR]) begin
            ovr_reg <= 1'b0;
        end
    end

    // transmit queue storage
    always_ff @(posedge clk_sys) begin
        if (txStore) begin
            txMem[txWr_reg] <= wData_reg[7:0];
        end else if (txOverwrite) begin
            txMem[txRd_reg] <= wData_reg[7:0];
        end
    end

    // transmit pointers and fill level; full-queue writes are lost with queues on, overwrite the pending byte with queues off
    always_ff @(posedge clk_sys) begin
        if (reset || qFlush) begin
            txWr_reg <= '0;
            txRd_reg <= '0;
            txCnt_reg <= '0;
        end else begin
            if (txStore) begin
                txWr_reg <= txWr_reg + PW'(1);
            end
            if (txPop) begin
                txRd_reg <= txRd_reg + PW'(1);
            end
            txCnt_reg <= txCnt_reg + CW'(txStore) - CW'(txPop);
        end
    end

    // output stage to the serialiser, steered by the mode at load time
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            txValid_reg <= 1'b0;
            txByte_reg <= USP_BYTE_RESET;
            txOnIr_reg <= 1'b0;
        end else if (txPop) begin
            txValid_reg <= 1'b1;
            txByte_reg <= txMem[txRd_reg];
            txOnIr_reg <= irMode;
        end else if (txTaken) begin
            txValid_reg <= 1'b0;
        end
    end

    // control register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl_reg <= USP_CTRL_RESET;
        end else if (wrDo && wrCtrl && wStrb0_reg) begin
            ctrl_reg <= wData_reg[1:0];
        end
    end

    // write address and data are taken independently, in either order
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            awHave_reg <= 1'b0;
            wHave_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            awAddr_reg <= 32'h0;
            wData_reg <= 32'h0;
            wStrb0_reg <= 1'b0;
        end else begin
            awready_reg <= awvalid && !awready_reg && !awHave_reg && !bvalid_reg;
            wready_reg <= wvalid && !wready_reg && !wHave_reg && !bvalid_reg;
            if (awvalid && awready_reg) begin
                awHave_reg <= 1'b1;
                awAddr_reg <= awaddr;
            end else if (wrDo) begin
                awHave_reg <= 1'b0;
            end
            if (wvalid && wready_reg) begin
                wHave_reg <= 1'b1;
                wData_reg <= wdata;
                wStrb0_reg <= wstrb[0];
            end else if (wrDo) begin
                wHave_reg <= 1'b0;
            end
        end
    end

    // write response once both halves are in
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= USP_RESP_OKAY;
        end else if (wrDo) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wrOk ? USP_RESP_OKAY : USP_RESP_SLVERR;
        end else if (bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // read channel: data latched at the address handshake
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= USP_RESP_OKAY;
        end else begin
            arready_reg <= arvalid && !arready_reg && !rvalid_reg;
            if (rdDo) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rdMux;
                rresp_reg <= rdOk ? USP_RESP_OKAY : USP_RESP_SLVERR;
            end else if (rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // status flags registered for the line status logic
    logic dr_reg, tx_holding_empty_flag_reg;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            dr_reg <= 1'b0;
            tx_holding_empty_flag_reg <= 1'b1;
        end else begin
            dr_reg <= (rxCnt_reg + CW'(rxStore) - CW'(rxPop)) != '0;
            tx_holding_empty_flag_reg <= (txCnt_reg + CW'(txStore) - CW'(txPop)) == '0;
        end
    end

    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
    assign txByte = txByte_reg;
    assign txValid = txValid_reg;
    assign txOnIr = txOnIr_reg;
    assign dataReady = dr_reg;
    assign overrunErr = ovr_reg;
    assign txHoldEmpty = tx_holding_empty_flag_reg;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    // checks on queue and bus behaviour
    chk_rx_route_sel: assert property (rxStore && !qFlush |=>
        rxMem[$past(rxWr_reg)] == $past(rxIn)) else $error("rx byte misrouted");
    chk_rx_overrun_flag: assert property (rxOverrun |=> ovr_reg &&
        overrunErr) else $error("overrun not flagged");
    chk_rx_overwrite_head: assert property (rxOverwrite && !qFlush |=>
        rxHead == $past(rxIn)) else $error("unread byte not replaced");
    chk_rx_full_keep: assert property (qEn && rxPush && rxBlocked && !qFlush
        |=> $stable(rxCnt_reg) && $stable(rxWr_reg)) else $error("full rx changed");
    chk_rd_head_data: assert property (rdDo && rdShadow |=> rvalid &&
        rdata[7:0] == $past(rxHead)) else $error("read not queue head");
    chk_upper_zero: assert property (rdDo && rdShadow |=>
        rdata[31:8] == 24'h0) else $error("reserved bits nonzero");
    chk_tx_single_clear: assert property (!qEn && txWrite && txCnt_reg == '0
        && !qFlush |=> !txHoldEmpty && txCnt_reg == CW'(1)) else $error("empty not cleared");
    chk_tx_pend_overwrite: assert property (txOverwrite && !qFlush |=>
        txCnt_reg == CW'(1) && txMem[txRd_reg] == $past(wData_reg[7:0]))
        else $error("pending byte not overwritten");
    chk_tx_fill_depth: assert property (qEn && txWrite && !txPop && !qFlush
        && txCnt_reg < CW'(DEPTH) |=> txCnt_reg == $past(txCnt_reg) + CW'(1))
        else $error("tx queue refused room");
    chk_tx_full_drop: assert property (qEn && txWrite && txBlocked && !qFlush
        |=> $stable(txCnt_reg) && $stable(txWr_reg)) else $error("full tx accepted");
    chk_tx_mode_route: assert property (txPop |=> txValid &&
        txOnIr == $past(irMode)) else $error("tx output misrouted");
    chk_bus_resp_bound: assert property (wrDo |=> bvalid) else $error("no write response");

    cov_rx_overrun: cover property (rxOverrun && qEn);
    cov_rx_replace: cover property (rxOverwrite);
    cov_tx_fill: cover property (qEn && txCnt_reg == CW'(DEPTH));
    cov_tx_drop: cover property (qEn && txWrite && txBlocked);
endmodule : usp_shadow_port

// ### usp_line_model.sv
// line-side partner: deserialiser bytes in, serialiser bytes out
`timescale 1ns/1ps
module usp_line_model (
    input wire logic clk_sys,
    input wire logic [7:0] txByte,
    input wire logic txValid,
    input wire logic txOnIr,
    output logic txTaken,
    output logic [7:0] rxLineByte,
    output logic rxLineValid,
    output logic [7:0] rxIrByte,
    output logic rxIrValid
);
    logic stall = 1'b0; // bench holds the serialiser busy with this
    logic [8:0] sentQ[$]; // {infrared, byte} in the order taken
    initial begin
        txTaken = 1'b0;
        rxLineByte = 8'hA5;
        rxLineValid = 1'b0;
        rxIrByte = 8'h5A;
        rxIrValid = 1'b0;
    end
    // serialiser accepts promptly or slowly at random, never while stalled
    always @(posedge clk_sys) begin
        txTaken <= !stall && ($urandom_range(0, 2) != 0);
    end
    // mid-cycle look at what the next edge transfers, so no edge race
    always @(negedge clk_sys) begin
        if (txValid && txTaken) begin
            sentQ.push_back({txOnIr, txByte});
        end
    end
    // one byte as a one-cycle pulse; idle data lines show the inverse, not the last byte
    task automatic send(input logic [7:0] b, input bit onIr);
        @(posedge clk_sys);
        rxLineByte <= onIr ? ~b : b;
        rxIrByte <= onIr ? b : ~b;
        rxLineValid <= !onIr;
        rxIrValid <= onIr;
        @(posedge clk_sys);
        rxLineValid <= 1'b0;
        rxIrValid <= 1'b0;
        rxLineByte <= ~b;
        rxIrByte <= ~b;
    endtask : send
endmodule : usp_line_model

// ### usp_shadow_port_tb.sv
// self-checking bench for the shadow data window with its line-side partner
`timescale 1ns/1ps
module usp_shadow_port_tb;
    import usp_pkg::*;
    localparam int DEPTH = 4; // small queue keeps fill and overflow short
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic [3:0] wstrb = 4'hF; // full word unless a test drops the low lane
    logic bready = 1'b1, rready = 1'b1; // master always takes answers
    logic awready, wready, bvalid, arready, rvalid, txValid, txOnIr, txTaken;
    logic [1:0] bresp, rresp;
    logic [7:0] rxLineByte, rxIrByte, txByte;
    logic rxLineValid, rxIrValid, dataReady, overrunErr, txHoldEmpty;
    int num_errors = 0;
    int n_tests = 0;
    bit qen, irMode, ovr; // model of control bits and sticky overrun
    logic [7:0] rxQ[$]; // model of the receive holding/queue
    logic [8:0] expTx[$]; // bytes the serialiser should get, with infrared flag
    int i;
    always #2.5 clk_sys = ~clk_sys;
    usp_shadow_port #(.DEPTH(DEPTH)) usp_shadow_port_i (.clk_sys(clk_sys), .reset(reset),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .rxLineByte(rxLineByte), .rxLineValid(rxLineValid),
        .rxIrByte(rxIrByte), .rxIrValid(rxIrValid), .txByte(txByte), .txValid(txValid),
        .txOnIr(txOnIr), .txTaken(txTaken), .dataReady(dataReady), .overrunErr(overrunErr),
        .txHoldEmpty(txHoldEmpty));
    usp_line_model usp_line_model_i (.clk_sys(clk_sys), .txByte(txByte), .txValid(txValid),
        .txOnIr(txOnIr), .txTaken(txTaken), .rxLineByte(rxLineByte),
        .rxLineValid(rxLineValid), .rxIrByte(rxIrByte), .rxIrValid(rxIrValid));
    // one comparison, counted; four-state so an unknown matches only an unknown
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // AXI4-Lite write; handshakes looked at mid-cycle, acted on at the following edge
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        bit aOk, wOk, bOk;
        logic [1:0] rsp;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!bOk) begin
            @(negedge clk_sys);
            aOk = awvalid && awready;
            wOk = wvalid && wready;
            bOk = bvalid;
            rsp = bresp;
            @(posedge clk_sys);
            if (aOk) awvalid <= 1'b0;
            if (wOk) wvalid <= 1'b0;
        end
        chk({30'h0, rsp}, {30'h0, er});
    endtask : wr
    // AXI4-Lite read with expected data and answer code
    task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
        bit aOk, rOk;
        logic [31:0] d;
        logic [1:0] rsp;
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        while (!rOk) begin
            @(negedge clk_sys);
            aOk = arvalid && arready;
            rOk = rvalid;
            d = rdata;
            rsp = rresp;
            @(posedge clk_sys);
            if (aOk) arvalid <= 1'b0;
        end
        chk(d, ed);
        chk({30'h0, rsp}, {30'h0, er});
    endtask : rd
    // one received byte through the partner, then flags against the model
    task automatic rx(input logic [7:0] b, input bit onIr);
        usp_line_model_i.send(b, onIr);
        @(negedge clk_sys);
        if (onIr == irMode) begin
            if (qen && rxQ.size() >= DEPTH) begin
                ovr = 1'b1;
            end else if (!qen && rxQ.size() != 0) begin
                ovr = 1'b1;
                rxQ[0] = b;
            end else begin
                rxQ.push_back(b);
            end
        end
        chk(dataReady, rxQ.size() != 0);
        chk(overrunErr, ovr);
    endtask : rx
    // data port read, made only while data is flagged ready
    task automatic rdData(input logic [31:0] a);
        chk(dataReady, 1'b1);
        rd(a, {24'h0, rxQ.pop_front()}, USP_RESP_OKAY);
    endtask : rdData
    // data port write to a random alias, with junk in the reserved upper bits
    task automatic wrTx(input logic [7:0] b);
        wr(USP_SHADOW_BASE + 32'(4 * $urandom_range(0, 15)),
            {24'($urandom_range(0, 32'hFFFFFF)), b}, USP_RESP_OKAY);
    endtask : wrTx
    // let the serialiser run, then compare everything it took
    task automatic drain();
        int n;
        @(posedge clk_sys);
        usp_line_model_i.stall <= 1'b0;
        for (n = 0; n < 400 && usp_line_model_i.sentQ.size() < expTx.size(); n++)
            @(posedge clk_sys);
        repeat (10) @(posedge clk_sys);
        chk(usp_line_model_i.sentQ.size(), expTx.size());
        while (expTx.size() != 0 && usp_line_model_i.sentQ.size() != 0)
            chk({23'h0, usp_line_model_i.sentQ.pop_front()}, {23'h0, expTx.pop_front()});
        expTx.delete();
        usp_line_model_i.sentQ.delete();
    endtask : drain
    task automatic setCtrl(input bit q, input bit ir);
        qen = q;
        irMode = ir;
        rxQ.delete();
        wr(USP_CTRL_ADDR, {30'h0, ir, q}, USP_RESP_OKAY);
    endtask : setCtrl
    task automatic done(input string s);
        $display("test %0s finished, errors so far %0d", s, num_errors);
    endtask : done
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    // watchdog: the whole run needs only a few hundred cycles
    initial begin
        #200000;
        num_errors++;
        end_of_test();
    end
    initial begin
        void'($urandom(32'hC010));
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        // reset state, unmapped places
        rd(USP_STAT_ADDR, 32'h0000_0020, USP_RESP_OKAY);
        rd(USP_SHADOW_BASE - 32'h4, 32'h0, USP_RESP_SLVERR);
        wr(USP_STAT_ADDR + 32'h4, 32'hFF, USP_RESP_SLVERR);
        done("reset");
        // queues off: unread byte replaced, overrun flagged and cleared
        for (i = 0; i < 3; i++) rx($urandom_range(0, 255), 1'b0);
        rdData(USP_SHADOW_WORD_11);
        wr(USP_STAT_ADDR, 32'h2, USP_RESP_OKAY);
        ovr = 1'b0;
        rd(USP_STAT_ADDR, 32'h0000_0020, USP_RESP_OKAY);
        done("rx_overwrite");
        // infrared mode: line input ignored, infrared byte received and sent
        setCtrl(1'b0, 1'b1);
        rx(8'h3C, 1'b0);
        rx(8'hC3, 1'b1);
        rdData(USP_SHADOW_BASE);
        wrTx(8'h96);
        expTx.push_back({1'b1, 8'h96});
        drain();
        done("infrared");
        // queues on: fill past depth, read oldest first across the first four aliases
        setCtrl(1'b1, 1'b0);
        for (i = 0; i <= DEPTH; i++) rx($urandom_range(0, 255), 1'b0);
        for (i = 0; i < DEPTH; i++) rdData(USP_SHADOW_BASE + 32'(4 * i));
        chk(dataReady, 1'b0);
        done("rx_queue");
        // queues off: later write overwrites the pending byte while stalled
        setCtrl(1'b0, 1'b0);
        usp_line_model_i.stall <= 1'b1;
        chk(txHoldEmpty, 1'b1);
        wrTx(8'h11);
        wrTx(8'h22);
        chk(txHoldEmpty, 1'b0);
        wrTx(8'h33);
        chk({txValid, txByte}, 9'h111);
        expTx.push_back(9'h011);
        expTx.push_back(9'h033);
        drain();
        done("tx_overwrite");
        // queues on: stage plus depth accepted, the extra write lost
        setCtrl(1'b1, 1'b0);
        usp_line_model_i.stall <= 1'b1;
        chk(txHoldEmpty, 1'b1);
        for (i = 0; i < DEPTH + 2; i++) begin
            wrTx(8'(i + 8'h40));
            if (i <= DEPTH) expTx.push_back({1'b0, 8'(i + 8'h40)});
        end
        chk(txHoldEmpty, 1'b0);
        drain();
        // low lane disabled: the data port write is ignored, nothing is sent
        wstrb <= 4'hE;
        wrTx(8'h77);
        wstrb <= 4'hF;
        drain();
        done("tx_queue");
        end_of_test();
    end
endmodule : usp_shadow_port_tb
